// >>> par_pkg.sv
// shared constants, types and helper functions of the parallel converter readout
package par_pkg;
  localparam int          NUM_CH         = 6;
  localparam int          NUM_PAIRS      = 3;
  localparam int          FIFO_DEPTH     = 6;
  localparam int          RES_W          = 12;
  localparam int          WORD_W         = 16;
  localparam int          CONV_CYCLES    = 16;
  localparam int          VALID_BIT      = 15;
  localparam int          TAG_MSB        = 14;
  localparam int          TAG_LSB        = 12;
  localparam int          RES_MSB        = 11;
  localparam logic [2:0]  SEL_RESET      = 3'h0;
  localparam logic [2:0]  SEL_CYCLE      = 3'h6;
  localparam logic [2:0]  SEL_FIFO       = 3'h7;
  localparam int          CLK_PERIOD_NS  = 8;
  localparam int          ADDR_SETUP_NS  = 10;
  localparam int          RD_LOW_NS      = 30;
  localparam int          RD_HIGH_NS     = 30;
  localparam int          ADDR_SETUP_CYC = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RD_LOW_CYC     = (RD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RD_HIGH_CYC    = (RD_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          DEV_LATENCY    = 1;

  typedef enum logic [1:0] {
    H_IDLE,
    H_SETUP,
    H_LOW,
    H_HIGH
  } par_host_state_t;

  // channel tag from pair index and first/second input
  function automatic logic [2:0] par_tag(input logic [1:0] pair, input logic second);
    par_tag = {pair, second};
  endfunction : par_tag

  // full output word: valid flag, channel tag, result
  function automatic logic [15:0] par_word(input logic [2:0] tag, input logic [11:0] res);
    par_word = {1'b1, tag, res};
  endfunction : par_word

  // byte mode lane: low byte first, then high byte, both on lines 7..0
  function automatic logic [15:0] par_lane(input logic [15:0] w, input logic byte_mode,
                                           input logic hi);
    if (!byte_mode) begin
      par_lane = w;
    end else if (hi) begin
      par_lane = {8'h00, w[15:8]};
    end else begin
      par_lane = {8'h00, w[7:0]};
    end
  endfunction : par_lane
endpackage : par_pkg

// >>> par_bus_if.sv
// parallel readout bus between converter and host
interface par_bus_if;
  logic        cs_n;
  logic        rd_n;
  logic        byte_sel;
  logic [2:0]  sel_code;
  logic [15:0] data;
  logic        data_oe_n;

  modport dev (
    input  cs_n,
    input  rd_n,
    input  byte_sel,
    input  sel_code,
    output data,
    output data_oe_n
  );

  modport host (
    output cs_n,
    output rd_n,
    output byte_sel,
    output sel_code,
    input  data,
    input  data_oe_n
  );
endinterface : par_bus_if

// >>> par_dev.sv
// converter end: conversion scheduling, result store and parallel readout
module par_dev #(
  parameter int CONV_CYCLES = par_pkg::CONV_CYCLES,
  parameter int FIFO_DEPTH  = par_pkg::FIFO_DEPTH
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  par_bus_if.dev           bus,
  input  wire logic        pair_a_sample_trigger_n_i,
  input  wire logic        pair_b_sample_trigger_n_i,
  input  wire logic        pair_c_sample_trigger_n_i,
  input  wire logic [71:0] sample_data_i,
  output logic             conv_busy_o
);
  localparam int CW = $clog2(CONV_CYCLES);
  localparam int FW = $clog2(FIFO_DEPTH + 1);

  if (CONV_CYCLES < 2 || FIFO_DEPTH != par_pkg::FIFO_DEPTH) begin : g_bad
    $error("par_dev: unsupported parameter values");
  end

  logic [2:0]    trig_q_r;
  logic [2:0]    held_r;
  logic [2:0]    trig_now;
  logic [2:0]    fall;
  logic [1:0]    q_r [3];
  logic [1:0]    q_nxt [3];
  logic [1:0]    qcnt_r;
  logic [1:0]    qcnt_nxt;
  logic          start;
  logic          busy_r;
  logic [1:0]    cur_pair_r;
  logic [CW-1:0] cyc_r;
  logic          done;
  logic [11:0]   hold_r [par_pkg::NUM_CH];
  logic          pend_v_r;
  logic [1:0]    pend_pair_r;
  logic          commit;
  logic [15:0]   res_r [par_pkg::NUM_CH];
  logic [15:0]   fifo_r [FIFO_DEPTH];
  logic [FW-1:0] fcnt_r;
  logic [2:0]    mode_r;
  logic [2:0]    rr_r;
  logic          byte_r;
  logic          byte_hi_r;
  logic          rd_act;
  logic          rd_act_q_r;
  logic          read_end;
  logic          word_adv;
  logic [15:0]   word_cur;
  logic [15:0]   data_r;
  logic          oe_n_r;

  assign trig_now = {pair_c_sample_trigger_n_i, pair_b_sample_trigger_n_i,
                     pair_a_sample_trigger_n_i};
  assign fall     = trig_q_r & ~trig_now & ~held_r;
  assign start    = !busy_r && (qcnt_r != 2'h0);
  assign done     = busy_r && (cyc_r == CW'(CONV_CYCLES - 1));
  assign rd_act   = !bus.cs_n && !bus.rd_n;
  assign read_end = rd_act_q_r && !rd_act;
  assign word_adv = !byte_r || byte_hi_r;
  assign commit   = pend_v_r && !rd_act && !read_end;

  // trigger edge registration
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      trig_q_r <= 3'h7;
    end else begin
      trig_q_r <= trig_now;
    end
  end

  // held pairs and their sampled inputs
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      held_r <= 3'h0;
      for (int i = 0; i < par_pkg::NUM_CH; i++) begin
        hold_r[i] <= 12'h000;
      end
    end else begin
      for (int p = 0; p < par_pkg::NUM_PAIRS; p++) begin
        if (fall[p]) begin
          held_r[p]       <= 1'b1;
          hold_r[2*p]     <= sample_data_i[24*p +: 12];
          hold_r[2*p + 1] <= sample_data_i[24*p + 12 +: 12];
        end else if (done && cur_pair_r == 2'(p)) begin
          held_r[p] <= 1'b0;
        end
      end
    end
  end

  // conversion queue next state: pop head, then append in A, B, C order
  always_comb begin
    int n;
    n     = int'(qcnt_r);
    q_nxt = q_r;
    if (start) begin
      q_nxt[0] = q_r[1];
      q_nxt[1] = q_r[2];
      n        = n - 1;
    end
    for (int p = 0; p < par_pkg::NUM_PAIRS; p++) begin
      if (fall[p] && n < 3) begin
        q_nxt[n] = 2'(p);
        n        = n + 1;
      end
    end
    qcnt_nxt = 2'(n);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      qcnt_r <= 2'h0;
      for (int i = 0; i < 3; i++) begin
        q_r[i] <= 2'h0;
      end
    end else begin
      qcnt_r <= qcnt_nxt;
      q_r    <= q_nxt;
    end
  end

  // converter
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      busy_r     <= 1'b0;
      cur_pair_r <= 2'h0;
      cyc_r      <= '0;
    end else if (start) begin
      busy_r     <= 1'b1;
      cur_pair_r <= q_r[0];
      cyc_r      <= '0;
    end else if (done) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      cyc_r <= cyc_r + CW'(1);
    end
  end

  // finished pair waits here while a read strobe is low
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pend_v_r    <= 1'b0;
      pend_pair_r <= 2'h0;
    end else if (done) begin
      pend_v_r    <= 1'b1;
      pend_pair_r <= cur_pair_r;
    end else if (commit) begin
      pend_v_r <= 1'b0;
    end
  end

  // per-input output registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < par_pkg::NUM_CH; i++) begin
        res_r[i] <= 16'h0000;
      end
    end else if (commit) begin
      for (int s = 0; s < 2; s++) begin
        res_r[2*pend_pair_r + s] <= par_pkg::par_word(par_pkg::par_tag(pend_pair_r, s[0]),
                                                      hold_r[2*pend_pair_r + s]);
      end
    end
  end

  // drain store: append above held entries, shift down on read
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fcnt_r <= '0;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifo_r[i] <= 16'h0000;
      end
    end else if (commit && mode_r == par_pkg::SEL_FIFO) begin
      for (int s = 0; s < 2; s++) begin
        if (int'(fcnt_r) + s < FIFO_DEPTH) begin
          fifo_r[int'(fcnt_r) + s] <= par_pkg::par_word(par_pkg::par_tag(pend_pair_r, s[0]),
                                                        hold_r[2*pend_pair_r + s]);
        end
      end
      fcnt_r <= (int'(fcnt_r) + 2 > FIFO_DEPTH) ? FW'(FIFO_DEPTH) : fcnt_r + FW'(2);
    end else if (read_end && word_adv && mode_r == par_pkg::SEL_FIFO && fcnt_r != '0) begin
      for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
        fifo_r[i] <= fifo_r[i + 1];
      end
      fifo_r[FIFO_DEPTH - 1] <= 16'h0000;
      fcnt_r                 <= fcnt_r - FW'(1);
    end
  end

  // select code and byte mode latched only while strobe and select are low
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_r <= par_pkg::SEL_RESET;
      byte_r <= 1'b0;
    end else if (rd_act) begin
      mode_r <= bus.sel_code;
      byte_r <= bus.byte_sel;
    end
  end

  // read position: byte phase and round-robin pointer
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rd_act_q_r <= 1'b0;
      byte_hi_r  <= 1'b0;
      rr_r       <= 3'h0;
    end else begin
      rd_act_q_r <= rd_act;
      if (read_end) begin
        byte_hi_r <= byte_r && !byte_hi_r;
        if (word_adv && mode_r == par_pkg::SEL_CYCLE) begin
          rr_r <= (rr_r == 3'(par_pkg::NUM_CH - 1)) ? 3'h0 : rr_r + 3'h1;
        end
      end
    end
  end

  // word chosen by the current select code
  always_comb begin
    unique case (bus.sel_code)
      par_pkg::SEL_CYCLE: word_cur = res_r[rr_r];
      par_pkg::SEL_FIFO:  word_cur = (fcnt_r != '0) ? fifo_r[0] : 16'h0000;
      default:            word_cur = res_r[bus.sel_code];
    endcase
  end

  // registered bus drive
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      data_r <= 16'h0000;
      oe_n_r <= 1'b1;
    end else begin
      oe_n_r <= !rd_act;
      data_r <= rd_act ? par_pkg::par_lane(word_cur, bus.byte_sel, byte_hi_r) : 16'h0000;
    end
  end

  assign bus.data      = data_r;
  assign bus.data_oe_n = oe_n_r;
  assign conv_busy_o   = busy_r;
endmodule : par_dev

// >>> par_host.sv
// host end: issues read strobes, assembles bytes and drains the store
module par_host (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  par_bus_if.host          bus,
  input  wire logic        cmd_valid_i,
  input  wire logic [2:0]  cmd_sel_i,
  input  wire logic        cmd_byte_i,
  output logic             cmd_ready_o,
  output logic             rsp_valid_o,
  output logic [15:0]      rsp_word_o,
  output logic             rsp_last_o
);
  localparam int LOW_CYC = par_pkg::RD_LOW_CYC + par_pkg::DEV_LATENCY;

  if (LOW_CYC > 15 || par_pkg::RD_HIGH_CYC > 15 || par_pkg::ADDR_SETUP_CYC > 15) begin : g_bad
    $error("par_host: strobe counts exceed counter");
  end

  par_pkg::par_host_state_t st_r;
  logic [3:0]               cnt_r;
  logic [2:0]               sel_r;
  logic                     byte_r;
  logic                     hi_r;
  logic                     init_r;
  logic                     more_r;
  logic [7:0]               lo_r;
  logic                     cs_n_r;
  logic                     rd_n_r;
  logic                     ready_r;
  logic                     rsp_v_r;
  logic [15:0]              rsp_w_r;
  logic                     rsp_l_r;
  logic [15:0]              word;
  logic                     drain;

  assign word  = byte_r ? {bus.data[7:0], lo_r} : bus.data;
  assign drain = (sel_r == par_pkg::SEL_FIFO) && word[par_pkg::VALID_BIT] && !init_r;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_r    <= par_pkg::H_SETUP;
      init_r  <= 1'b1;
      sel_r   <= par_pkg::SEL_FIFO;
      byte_r  <= 1'b0;
      hi_r    <= 1'b0;
      more_r  <= 1'b0;
      lo_r    <= 8'h00;
      cnt_r   <= 4'h0;
      cs_n_r  <= 1'b1;
      rd_n_r  <= 1'b1;
      ready_r <= 1'b0;
      rsp_v_r <= 1'b0;
      rsp_w_r <= 16'h0000;
      rsp_l_r <= 1'b0;
    end else begin
      rsp_v_r <= 1'b0;
      unique case (st_r)
        par_pkg::H_IDLE: begin
          if (cmd_valid_i && ready_r) begin
            sel_r   <= cmd_sel_i;
            byte_r  <= cmd_byte_i;
            hi_r    <= 1'b0;
            ready_r <= 1'b0;
            cnt_r   <= 4'h0;
            st_r    <= par_pkg::H_SETUP;
          end
        end
        par_pkg::H_SETUP: begin
          cs_n_r <= 1'b0;
          if (cnt_r == 4'(par_pkg::ADDR_SETUP_CYC - 1)) begin
            rd_n_r <= 1'b0;
            cnt_r  <= 4'h0;
            st_r   <= par_pkg::H_LOW;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        par_pkg::H_LOW: begin
          if (cnt_r == 4'(LOW_CYC - 1)) begin
            rd_n_r <= 1'b1;
            cnt_r  <= 4'h0;
            st_r   <= par_pkg::H_HIGH;
            if (byte_r && !hi_r) begin
              lo_r   <= bus.data[7:0];
              hi_r   <= 1'b1;
              more_r <= 1'b1;
            end else begin
              hi_r    <= 1'b0;
              more_r  <= drain;
              rsp_v_r <= !init_r;
              rsp_w_r <= word;
              rsp_l_r <= !drain;
            end
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        par_pkg::H_HIGH: begin
          if (cnt_r == 4'(par_pkg::RD_HIGH_CYC - 1)) begin
            cnt_r <= 4'h0;
            if (more_r) begin
              rd_n_r <= 1'b0;
              st_r   <= par_pkg::H_LOW;
            end else begin
              cs_n_r  <= 1'b1;
              init_r  <= 1'b0;
              ready_r <= 1'b1;
              st_r    <= par_pkg::H_IDLE;
            end
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
      endcase
    end
  end

  assign bus.cs_n     = cs_n_r;
  assign bus.rd_n     = rd_n_r;
  assign bus.byte_sel = byte_r;
  assign bus.sel_code = sel_r;
  assign cmd_ready_o  = ready_r;
  assign rsp_valid_o  = rsp_v_r;
  assign rsp_word_o   = rsp_w_r;
  assign rsp_last_o   = rsp_l_r;
endmodule : par_host

// >>> par_props.sv
// concurrent checks on the parallel readout bus
module par_props (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic        byte_sel,
  input wire logic [2:0]  sel_code,
  input wire logic [15:0] data,
  input wire logic        data_oe_n
);
  wire logic rd_act;
  assign rd_act = !cs_n && !rd_n;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  a_oe_needs_read: assert property (
    !data_oe_n |-> $past(rd_act) || $past(rd_act, 2)) else $error("data driven outside a read");
  a_oe_answer: assert property (
    $rose(rd_act) |-> ##[1:2] !data_oe_n) else $error("no data after read start");
  a_oe_release: assert property (
    $fell(rd_act) |-> ##[1:2] data_oe_n) else $error("data not released after read");
  a_idle_zero: assert property (
    data_oe_n |-> data == 16'h0000) else $error("idle data not zero");
  a_byte_upper_zero: assert property (
    rd_act && $past(rd_act) && byte_sel && !data_oe_n |-> data[15:8] == 8'h00)
    else $error("upper lines busy in byte mode");
  a_tag_in_range: assert property (
    !data_oe_n && !byte_sel && data[15] |-> data[14:12] <= 3'h5)
    else $error("bad channel tag");
  a_sel_held: assert property (
    rd_act && $past(rd_act) |-> $stable(sel_code) && $stable(byte_sel))
    else $error("select changed during strobe");
  a_init_read: assert property (
    $fell(reset_i) |-> ##[1:12] (rd_act && sel_code == 3'h7))
    else $error("no store mode read after reset");
  a_reset_quiet: assert property (
    $fell(reset_i) |-> data_oe_n && cs_n && rd_n) else $error("bus busy after reset");

  c_store_read: cover property (rd_act && sel_code == 3'h7 && $past(rd_act));
  c_cycle_byte: cover property (rd_act && sel_code == 3'h6 && byte_sel);
  c_reset_seen: cover property ($fell(reset_i));
endmodule : par_props

// >>> parallel_adc_readout_tb.sv
// self-checking bench joining converter and host ends
module parallel_adc_readout_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i;
  logic        reset_i;
  logic        trig_a_n;
  logic        trig_b_n;
  logic        trig_c_n;
  logic [71:0] smp_drv;
  logic        cmd_valid_i;
  logic [2:0]  cmd_sel_i;
  logic        cmd_byte_i;
  logic        cmd_ready_o;
  logic        rsp_valid_o;
  logic [15:0] rsp_word_o;
  logic        rsp_last_o;
  logic        conv_busy_o;
  logic [11:0] smp [6];
  logic [15:0] got_q [$];
  int          fail_count;
  int          comparisons;
  int          cycles;

  par_bus_if bus ();
  par_dev #(.CONV_CYCLES(4), .FIFO_DEPTH(6)) i_par_dev (
    .clk_i(clk_i), .reset_i(reset_i), .bus(bus),
    .pair_a_sample_trigger_n_i(trig_a_n), .pair_b_sample_trigger_n_i(trig_b_n),
    .pair_c_sample_trigger_n_i(trig_c_n), .sample_data_i(smp_drv), .conv_busy_o(conv_busy_o));
  par_host i_par_host (
    .clk_i(clk_i), .reset_i(reset_i), .bus(bus), .cmd_valid_i(cmd_valid_i),
    .cmd_sel_i(cmd_sel_i), .cmd_byte_i(cmd_byte_i), .cmd_ready_o(cmd_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_word_o(rsp_word_o), .rsp_last_o(rsp_last_o));
  par_props i_par_props (
    .clk_i(clk_i), .reset_i(reset_i), .cs_n(bus.cs_n), .rd_n(bus.rd_n),
    .byte_sel(bus.byte_sel), .sel_code(bus.sel_code), .data(bus.data),
    .data_oe_n(bus.data_oe_n));

  always #4 clk_i = ~clk_i;

  function automatic logic [15:0] exp_word(input int i);
    exp_word = {1'b1, 3'(i), smp[i]};
  endfunction : exp_word

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  // one host command, words gathered until the last one
  task automatic run_cmd(input logic [2:0] sel, input logic bm);
    int   n;
    logic done_f;
    got_q.delete();
    n = 0;
    done_f = 1'b0;
    while (cmd_ready_o !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    cmd_sel_i = sel;
    cmd_byte_i = bm;
    cmd_valid_i = 1'b1;
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    n = 0;
    while (n < 400 && !done_f) begin
      @(negedge clk_i);
      n++;
      if (rsp_valid_o === 1'b1) begin
        got_q.push_back(rsp_word_o);
        done_f = (rsp_last_o === 1'b1);
      end
    end
    if (!done_f) begin
      fail_count++;
      $display("[ERR] %0t command not finished", $time);
    end
  endtask : run_cmd

  task automatic wait_idle();
    int quiet;
    quiet = 0;
    repeat (200) begin
      @(negedge clk_i);
      quiet = (conv_busy_o === 1'b0) ? quiet + 1 : 0;
      if (quiet == 6) break;
    end
    if (quiet != 6) begin
      fail_count++;
      $display("[ERR] %0t converter never idle", $time);
    end
  endtask : wait_idle

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      $display("[ERR] %0t run hung", $time);
      print_verdict();
    end
  end

  initial begin
    clk_i = 1'b0;
    reset_i = 1'b1;
    {trig_a_n, trig_b_n, trig_c_n} = 3'h7;
    {cmd_valid_i, cmd_sel_i, cmd_byte_i} = 5'h00;
    fail_count = 0;
    comparisons = 0;
    cycles = 0;
    smp = '{12'h1a1, 12'h2a2, 12'h3b3, 12'h4b4, 12'h5c5, 12'h6c6};
    smp_drv = {smp[5], smp[4], smp[3], smp[2], smp[1], smp[0]};
    repeat (4) @(negedge clk_i);
    reset_i = 1'b0;
    run_cmd(3'h0, 1'b0);
    check({15'h0, got_q[0][15]}, 16'h0000);
    run_cmd(3'h7, 1'b0);
    check(16'(got_q.size()), 16'h0001);
    // all pairs in one cycle, then a repeat fall on pair a with other data
    {trig_a_n, trig_b_n, trig_c_n} = 3'h0;
    @(negedge clk_i);
    trig_a_n = 1'b1;
    smp_drv[23:0] = 24'h0f00f0;
    @(negedge clk_i);
    trig_a_n = 1'b0;
    wait_idle();
    {trig_a_n, trig_b_n, trig_c_n} = 3'h7;
    smp_drv[23:0] = {smp[1], smp[0]};
    run_cmd(3'h7, 1'b0);
    check(16'(got_q.size()), 16'h0007);
    for (int i = 0; i < 6; i++) check(got_q[i], exp_word(i));
    check({15'h0, got_q[6][15]}, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      run_cmd(3'(i), 1'b0);
      check(got_q[0], exp_word(i));
      check(16'(got_q.size()), 16'h0001);
    end
    for (int i = 0; i < 7; i++) begin
      run_cmd(3'h6, 1'b0);
      check(got_q[0], exp_word(i % 6));
    end
    run_cmd(3'h6, 1'b1);
    check(got_q[0], exp_word(1));
    run_cmd(3'h6, 1'b0);
    check(got_q[0], exp_word(2));
    run_cmd(3'h3, 1'b1);
    check(got_q[0], exp_word(3));
    // reset in mid conversion
    trig_b_n = 1'b0;
    repeat (2) @(negedge clk_i);
    reset_i = 1'b1;
    trig_b_n = 1'b1;
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    @(negedge clk_i);
    check({15'h0, conv_busy_o}, 16'h0000);
    run_cmd(3'h2, 1'b0);
    check({15'h0, got_q[0][15]}, 16'h0000);
    trig_a_n = 1'b0;
    @(negedge clk_i);
    check({15'h0, conv_busy_o}, 16'h0000);
    @(negedge clk_i);
    check({15'h0, conv_busy_o}, 16'h0001);
    wait_idle();
    trig_a_n = 1'b1;
    run_cmd(3'h6, 1'b0);
    check(got_q[0], exp_word(0));
    run_cmd(3'h7, 1'b0);
    check(16'(got_q.size()), 16'h0001);
    // one pair into the store, drained in byte mode
    trig_c_n = 1'b0;
    wait_idle();
    trig_c_n = 1'b1;
    run_cmd(3'h7, 1'b1);
    check(16'(got_q.size()), 16'h0003);
    check(got_q[0], exp_word(4));
    check(got_q[1], exp_word(5));
    print_verdict();
  end
endmodule : parallel_adc_readout_tb
